// ### rtl/iom_pkg.sv
// Constants and types for the peripheral I/O address space block.
// Assumes a single core clock domain and one core request per cycle.
// Behaviour
// RULE_01: Software writes zero to reserved bit positions whenever it touches a register.
// RULE_02: Software never writes to an I/O location marked reserved.
// RULE_03: Single-bit set and clear reach only I/O locations 0x00 to 0x1F.
// RULE_04: In I/O locations 0x00 to 0x1F one bit can be tested to skip when it is clear or set.
// RULE_05: Write-one-to-clear flags clear where a one is written and keep their value under a zero.
// RULE_06: Single-bit set and clear change only the addressed bit and leave other flags alone.
// RULE_07: The dedicated I/O read and write instructions decode addresses 0x00 to 0x3F.
// RULE_08: Through load and store an I/O register sits at its I/O address plus 0x20.
// RULE_09: The dedicated I/O address field holds exactly 64 locations and reaches nothing beyond.
// RULE_10: The extended region 0x60 to 0xFF is reached only by load and store, in every form.
// RULE_11: Reserved locations read as zero and writes to them change no state.
package iom_pkg;

  localparam int DATA_W = 8;
  localparam int IO_ADDR_W = 6;
  localparam int BIT_ADDR_W = 5;
  localparam int SPACE_DEPTH = 224;
  localparam logic [7:0] IO_DS_OFFSET = 8'h20;
  localparam logic [5:0] IO_LAST = 6'h3F;
  localparam logic [4:0] BIT_LAST = 5'h1F;
  localparam logic [7:0] EXT_FIRST = 8'h60;
  localparam logic [7:0] EXT_LAST = 8'hFF;
  localparam logic [7:0] RSVD_FIRST = 8'hC7;
  localparam logic [7:0] W1C_FIRST = 8'h35;
  localparam logic [7:0] W1C_LAST = 8'h37;
  localparam logic [7:0] RESET_VAL = 8'h00;

  typedef enum logic [1:0] {
    PATH_NONE = 2'b00,
    PATH_DS = 2'b01,
    PATH_IO = 2'b11,
    PATH_BIT = 2'b10
  } iom_path_type;

endpackage

// ### rtl/iom_decode.sv
// Address decoder of the I/O space: turns each access path into a data-space address.
// Assumes the caller has already chosen one path for the cycle.
`timescale 1ns/1ps
module iom_decode (
  input wire iom_pkg::iom_path_type path,
  input wire logic [7:0] ds_addr,
  input wire logic [iom_pkg::IO_ADDR_W-1:0] io_addr,
  input wire logic [iom_pkg::BIT_ADDR_W-1:0] bit_addr,
  output logic [7:0] daddr,
  output logic [7:0] idx,
  output logic mapped,
  output logic rsvd,
  output logic w1c
);
  import iom_pkg::*;

  always_comb begin
    case (path)
      // Six address bits give exactly 64 locations, never the extended region
      PATH_IO: daddr = {2'b00, io_addr} + IO_DS_OFFSET; // see RULE_07 see RULE_08 see RULE_09
      // Five address bits confine bit operations to the lowest 32 locations
      PATH_BIT: daddr = {3'b000, bit_addr} + IO_DS_OFFSET; // see RULE_03 see RULE_04
      // Load/store of every form is the only path above the I/O window
      PATH_DS: daddr = ds_addr; // see RULE_10
      default: daddr = 8'h00;
    endcase
  end

  always_comb begin
    mapped = (path != PATH_NONE) && (daddr >= IO_DS_OFFSET);
    idx = daddr - IO_DS_OFFSET;
    rsvd = mapped && (daddr >= RSVD_FIRST); // see RULE_11
    w1c = mapped && (daddr >= W1C_FIRST) && (daddr <= W1C_LAST);
  end

endmodule

// ### rtl/iom_space.sv
// Peripheral I/O register space with its three core access paths and bit operations.
// Assumes the core raises at most one request per cycle; if several come, load/store wins,
// then the dedicated I/O instructions, then the bit instructions.
// Assumes hw_set and periph_rd_addr come from peripheral logic on the same mclk.
`timescale 1ns/1ps
module iom_space (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ds_rd,
  input wire logic ds_wr,
  input wire logic [7:0] ds_addr,
  input wire logic [iom_pkg::DATA_W-1:0] ds_wdata,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [iom_pkg::IO_ADDR_W-1:0] io_addr,
  input wire logic [iom_pkg::DATA_W-1:0] io_wdata,
  input wire logic set_io_bit_instr,
  input wire logic clear_io_bit_instr,
  input wire logic skip_if_io_bit_set_instr,
  input wire logic skip_if_io_bit_clear_instr,
  input wire logic [iom_pkg::BIT_ADDR_W-1:0] bit_addr,
  input wire logic [2:0] bit_sel,
  input wire logic hw_set,
  input wire logic [7:0] hw_set_addr,
  input wire logic [iom_pkg::DATA_W-1:0] hw_set_mask,
  input wire logic [7:0] periph_rd_addr,
  output logic ds_hit,
  output logic [iom_pkg::DATA_W-1:0] rdata_q,
  output logic rvalid_q,
  output logic skip_q,
  output logic [iom_pkg::DATA_W-1:0] periph_rd_data_q
);
  import iom_pkg::*;

  // One byte for every data address from the start of the I/O window upward
  logic [DATA_W-1:0] mem_q [0:SPACE_DEPTH-1];
  iom_path_type path;
  logic is_write;
  logic is_read;
  logic is_test;
  logic [DATA_W-1:0] wdata;
  logic [7:0] daddr;
  logic [7:0] idx;
  logic mapped;
  logic rsvd;
  logic w1c;
  logic [DATA_W-1:0] old_val;
  logic [DATA_W-1:0] bit_mask;
  logic [DATA_W-1:0] new_val;
  logic wr_en;
  logic [7:0] hidx;
  logic hw_ok;
  logic [DATA_W-1:0] hw_val;

  ////////////////////////////////////////////////////////////////////////////////
  // Path selection

  always_comb begin
    // Lower-priority requests of the same cycle are dropped
    path = PATH_NONE;
    wdata = ds_wdata;
    if (ds_rd || ds_wr) begin
      path = PATH_DS;
    end else if (io_rd || io_wr) begin
      path = PATH_IO;
      wdata = io_wdata;
    end else if (set_io_bit_instr || clear_io_bit_instr ||
                 skip_if_io_bit_set_instr || skip_if_io_bit_clear_instr) begin
      path = PATH_BIT;
    end
  end

  always_comb begin
    case (path)
      // A store presented together with a load wins
      PATH_DS: begin
        is_write = ds_wr;
        is_read = ds_rd && !ds_wr;
        is_test = 1'b0;
      end
      PATH_IO: begin
        is_write = io_wr;
        is_read = io_rd && !io_wr;
        is_test = 1'b0;
      end
      PATH_BIT: begin
        is_write = set_io_bit_instr || clear_io_bit_instr;
        is_read = 1'b0;
        is_test = !is_write;
      end
      default: begin
        is_write = 1'b0;
        is_read = 1'b0;
        is_test = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode

  iom_decode iom_decode_i (
    .path(path),
    .ds_addr(ds_addr),
    .io_addr(io_addr),
    .bit_addr(bit_addr),
    .daddr(daddr),
    .idx(idx),
    .mapped(mapped),
    .rsvd(rsvd),
    .w1c(w1c)
  );

  // Load/store below the I/O window belongs to the working registers
  assign ds_hit = (path == PATH_DS) && mapped; // see RULE_08

  ////////////////////////////////////////////////////////////////////////////////
  // Write value

  always_comb begin
    // Unmapped addresses read the reset value, which keeps the index in range
    old_val = mapped ? mem_q[idx] : RESET_VAL;
    bit_mask = DATA_W'(1) << bit_sel;
    new_val = old_val;
    if (path == PATH_BIT) begin
      if (set_io_bit_instr) begin
        // A one on a flag clears only that flag; neighbours stay pending
        new_val = w1c ? (old_val & ~bit_mask) : (old_val | bit_mask); // see RULE_06
      end else if (clear_io_bit_instr) begin
        new_val = w1c ? old_val : (old_val & ~bit_mask); // see RULE_06
      end
    end else begin
      // Plain bytes take the data; flag bytes clear where ones are written
      new_val = w1c ? (old_val & ~wdata) : wdata; // see RULE_05
    end
  end

  // Reserved locations drop every write
  assign wr_en = is_write && mapped && !rsvd; // see RULE_11

  ////////////////////////////////////////////////////////////////////////////////
  // Hardware flag setting; a set in the same cycle as a clear wins

  always_comb begin
    hidx = hw_set_addr - IO_DS_OFFSET;
    hw_ok = hw_set && (hw_set_addr >= IO_DS_OFFSET) && (hw_set_addr < RSVD_FIRST);
    // Merging with the core's new value lets a set survive a clearing write
    if (wr_en && (hidx == idx)) begin
      hw_val = new_val | hw_set_mask;
    end else begin
      hw_val = mem_q[hidx] | hw_set_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < SPACE_DEPTH; i++) begin
        mem_q[i] <= RESET_VAL;
      end
    end else begin
      if (wr_en) begin
        mem_q[idx] <= new_val;
      end
      // The later assignment carries the merged value when both hit one byte
      if (hw_ok) begin
        mem_q[hidx] <= hw_val;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Core read data

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_q <= RESET_VAL;
      rvalid_q <= 1'b0;
    end else begin
      // Loads below the window belong to the working registers and get no answer
      rvalid_q <= is_read && mapped;
      if (is_read && mapped) begin
        rdata_q <= rsvd ? RESET_VAL : old_val; // see RULE_11
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bit test and skip
  // The pulse lasts one cycle; the core drops the next instruction on it

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      skip_q <= 1'b0;
    end else if (is_test) begin
      if (skip_if_io_bit_set_instr) begin
        skip_q <= old_val[bit_sel]; // see RULE_04
      end else begin
        skip_q <= !old_val[bit_sel]; // see RULE_04
      end
    end else begin
      skip_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Peripheral view of the stored contents
  // The byte appears one cycle after its address; outside the map it reads zero

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      periph_rd_data_q <= RESET_VAL;
    end else if ((periph_rd_addr >= IO_DS_OFFSET) && (periph_rd_addr < RSVD_FIRST)) begin
      periph_rd_data_q <= mem_q[8'(periph_rd_addr - IO_DS_OFFSET)];
    end else begin
      periph_rd_data_q <= RESET_VAL;
    end
  end

endmodule

// ### tb/iom_core_model.sv
// Processor core model: issues one I/O space request per call.
// Assumes each call starts just after a falling mclk edge.
`timescale 1ns/1ps
module iom_core_model (
  input wire logic mclk,
  output logic ds_rd,
  output logic ds_wr,
  output logic io_rd,
  output logic io_wr,
  output logic set_io_bit_instr,
  output logic clear_io_bit_instr,
  output logic skip_if_io_bit_set_instr,
  output logic skip_if_io_bit_clear_instr,
  output logic [7:0] ds_addr,
  output logic [7:0] ds_wdata,
  output logic [7:0] io_wdata,
  output logic [5:0] io_addr,
  output logic [4:0] bit_addr,
  output logic [2:0] bit_sel
);
  logic [7:0] req;
  assign {skip_if_io_bit_clear_instr, skip_if_io_bit_set_instr, clear_io_bit_instr,
    set_io_bit_instr, io_wr, io_rd, ds_wr, ds_rd} = req;
  initial {req, ds_addr, ds_wdata, io_wdata, io_addr, bit_addr, bit_sel} = '0;
  // Kinds: 0 load, 1 store, 2 in, 3 out, 4 set, 5 clear, 6 test set, 7 test clear
  task automatic op(inout int k, input logic [7:0] a, d, input logic [2:0] b);
    if (k == 1 && a >= 8'hC7) k = 0; // Stores to unused space become loads
    {ds_addr, io_addr, bit_addr, bit_sel} = {a, a[5:0], a[4:0], b};
    {ds_wdata, io_wdata} = {d, d}; // Whole bytes, no unused bits in use
    req = 8'h01 << k;
    @(negedge mclk);
    req = 8'h00;
    {ds_addr, ds_wdata, io_wdata} = ~{a, d, d};
  endtask
endmodule

// ### tb/iom_space_sva.sv
// Checker of the I/O space block, bound to every iom_space instance.
// Assumes requests change only between rising mclk edges.
`timescale 1ns/1ps
module iom_space_sva (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ds_rd,
  input wire logic ds_wr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic hw_set,
  input wire logic ds_hit,
  input wire logic rvalid_q,
  input wire logic skip_q,
  input wire logic set_io_bit_instr,
  input wire logic clear_io_bit_instr,
  input wire logic skip_if_io_bit_set_instr,
  input wire logic skip_if_io_bit_clear_instr,
  input wire logic [7:0] ds_addr,
  input wire logic [7:0] ds_wdata,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] periph_rd_addr,
  input wire logic [7:0] rdata_q,
  input wire logic [7:0] periph_rd_data_q,
  input wire logic [5:0] io_addr,
  input wire logic [4:0] bit_addr,
  input wire logic [2:0] bit_sel
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic ld, busy;
  assign ld = ds_rd && !ds_wr;
  assign busy = ds_rd | ds_wr | io_rd | io_wr | hw_set | clear_io_bit_instr;
  a_hit_range: assert property ((ds_rd || ds_wr) |-> ds_hit == (ds_addr >= 8'h20))
    else $error("ds_hit wrong for address");
  a_read_answer: assert property ((ld && ds_hit) ||
    (io_rd && !io_wr && !ds_rd && !ds_wr) |=> rvalid_q)
    else $error("read not answered");
  a_valid_cause: assert property (rvalid_q |-> $past(ld && ds_hit || io_rd))
    else $error("read answer without request");
  a_rsvd_zero: assert property (ld && ds_addr >= 8'hC7 |=> rdata_q == 8'h00)
    else $error("unused location not zero");
  a_skip_cause: assert property (skip_q |->
    $past(skip_if_io_bit_set_instr | skip_if_io_bit_clear_instr))
    else $error("skip without bit test");
  a_io_alias: assert property (io_wr && !ds_rd && !ds_wr && !hw_set
    && io_addr < 6'h15 ##1 !busy && !set_io_bit_instr
    ##1 ld && ds_addr == {2'b00, $past(io_addr, 2)} + 8'h20
    |=> rdata_q == $past(io_wdata, 3))
    else $error("I/O write not seen at offset address");
  a_bit_only: assert property (set_io_bit_instr && !busy && bit_addr < 5'h15
    && periph_rd_addr == {3'b000, bit_addr} + 8'h20
    ##1 !busy && !set_io_bit_instr && $stable(periph_rd_addr)
    |=> periph_rd_data_q == ($past(periph_rd_data_q) | (8'h01 << $past(bit_sel, 2))))
    else $error("bit set disturbed other bits");
  a_flag_clear: assert property (ds_wr && ds_addr == 8'h35 && !hw_set
    && periph_rd_addr == 8'h35 ##1 !busy && !set_io_bit_instr && periph_rd_addr == 8'h35
    |=> periph_rd_data_q == ($past(periph_rd_data_q) & ~$past(ds_wdata, 2)))
    else $error("flag byte write wrong");
endmodule
bind iom_space iom_space_sva iom_space_sva_i (.*);

// ### tb/iom_space_test.sv
// Self-checking bench of the I/O space block: fixed corners, then random core traffic.
// Assumes the core model and the checker are compiled first.
`timescale 1ns/1ps
module iom_space_test;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ds_rd, ds_wr, io_rd, io_wr, hw_set, ds_hit, rvalid_q, skip_q;
  logic set_io_bit_instr, clear_io_bit_instr, skip_if_io_bit_set_instr, skip_if_io_bit_clear_instr;
  logic [7:0] ds_addr, ds_wdata, io_wdata, hw_set_addr, hw_set_mask, periph_rd_addr;
  logic [7:0] rdata_q, periph_rd_data_q, mem [256];
  logic [5:0] io_addr;
  logic [4:0] bit_addr;
  logic [2:0] bit_sel;
  int fails = 0;
  int total_checks = 0;
  int seed = 32'hc136;
  iom_space iom_space_i (.*);
  iom_core_model iom_core_model_i (.*);
  always #2 mclk = ~mclk;
  task automatic check(string what, logic [7:0] e, s);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic run(int k, logic [7:0] a, d, logic [2:0] b);
    logic [7:0] da;
    logic w1c;
    da = k < 2 ? a : k < 4 ? {2'b00, a[5:0]} + 8'h20 : {3'b000, a[4:0]} + 8'h20;
    w1c = da >= 8'h35 && da <= 8'h37;
    periph_rd_addr = da;
    iom_core_model_i.op(k, a, d, b);
    check("rvalid", da >= 8'h20 && !k[0] && k < 4, rvalid_q);
    if (da >= 8'h20 && k < 4 && !k[0]) check("rdata", mem[da], rdata_q);
    check("skip", k > 5 && (mem[da][b] ^ (k == 7)), skip_q);
    check("periph", da >= 8'h20 && da < 8'hC7 ? mem[da] : 8'h00, periph_rd_data_q);
    if (da >= 8'h20 && k[0] && k < 4) mem[da] = w1c ? mem[da] & ~d : d;
    if (k == 4) mem[da][b] = !w1c;
    if (k == 5 && !w1c) mem[da][b] = 1'b0;
    @(negedge mclk);
  endtask
  task automatic summarize();
    $display("Checks %0d, errors %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {hw_set, hw_set_addr, hw_set_mask, periph_rd_addr} = '0;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    run(3, 8'h3F, 8'h5A, 0);
    run(0, 8'h5F, 0, 0);
    run(1, 8'h40, 8'hA5, 0);
    run(2, 8'h20, 0, 0);
    run(3, 8'h05, 8'hC3, 0);
    run(0, 8'h25, 0, 0);
    run(1, 8'h60, 8'h3C, 0);
    run(0, 8'h60, 0, 0);
    run(0, 8'h1F, 0, 0);
    run(1, 8'hFF, 8'h77, 0);
    {hw_set, hw_set_addr, hw_set_mask} = {1'b1, 8'h35, 8'hFF};
    @(negedge mclk);
    hw_set = 1'b0;
    mem[8'h35] = 8'hFF;
    run(4, 8'h15, 0, 3);
    run(5, 8'h15, 0, 0);
    run(6, 8'h15, 0, 1);
    run(1, 8'h35, 8'h05, 0);
    run(0, 8'h35, 0, 0);
    {hw_set, hw_set_addr, hw_set_mask} = {1'b1, 8'h35, 8'h01};
    run(1, 8'h35, 8'h03, 0);
    hw_set = 1'b0;
    mem[8'h35] = mem[8'h35] | 8'h01;
    run(0, 8'h35, 0, 0);
    run(4, 8'h1F, 0, 7);
    run(7, 8'h1F, 0, 7);
    repeat (400) run($unsigned($random(seed)) % 8, 8'($random(seed)),
      8'($random(seed)), 3'($random(seed)));
    summarize();
  end
endmodule
